// ===== core/io_page_consts.svh
// constants for the peripheral register page and vector table
// assumes an 8-bit core bus with 16-bit byte addresses
`ifndef IO_PAGE_CONSTS_SVH
`define IO_PAGE_CONSTS_SVH
`define PAGE_BYTES 48
`define PAGE_TOP 16'h002F
`define OFF_PORT3_DATA 6'h03
`define OFF_IRQ_FLAGS_TWO 6'h08
`define OFF_SIB_STEP 6'h14
`define OFF_BUS_CONTROL 6'h1B
`define OFF_MON_COUNT_LOW 6'h2A
`define OFF_MON_COUNT_HIGH 6'h2B
`define OFF_IRQ_FLAGS_ONE 6'h2C
`define OFF_PORT0_DATA 6'h00
`define OFF_PORT1_DATA 6'h01
`define OFF_PORT2_DATA 6'h02
`define OFF_PORT0_DIR 6'h04
`define OFF_PORT1_DIR 6'h05
`define OFF_PORT2_DIR 6'h06
`define OFF_PORT3_CS 6'h07
`define OFF_IRQ_ENABLE_TWO 6'h09
`define OFF_TIMER_CTRL_ONE 6'h0A
`define OFF_TIMER_CTRL_TWO 6'h0B
`define OFF_TIMER1_RELOAD_LOW 6'h0C
`define OFF_TIMER1_RELOAD_HIGH 6'h0D
`define OFF_TIMER2_RELOAD_LOW 6'h0E
`define OFF_TIMER2_RELOAD_HIGH 6'h0F
`define OFF_TIMER1_COUNT_LOW 6'h10
`define OFF_TIMER1_COUNT_HIGH 6'h11
`define OFF_TIMER2_COUNT_LOW 6'h12
`define OFF_TIMER2_COUNT_HIGH 6'h13
`define OFF_SIB_SHIFT0 6'h15
`define OFF_SIB_SHIFT1 6'h16
`define OFF_SIB_SHIFT2 6'h17
`define OFF_SIB_SHIFT3 6'h18
`define OFF_SIB_CTRL 6'h19
`define OFF_SIB_NODE 6'h1A
`define OFF_PORT4_DATA 6'h1C
`define OFF_PORT5_DATA 6'h1D
`define OFF_PORT4_DIR 6'h1E
`define OFF_PORT5_DIR 6'h1F
`define OFF_PORT6_DATA 6'h20
`define OFF_PORT6_DIR 6'h21
`define OFF_UART_CTRL 6'h22
`define OFF_UART_DATA 6'h23
`define OFF_TIMER_A_RELOAD_LOW 6'h24
`define OFF_TIMER_A_RELOAD_HIGH 6'h25
`define OFF_TIMER_A_COUNT_LOW 6'h26
`define OFF_TIMER_A_COUNT_HIGH 6'h27
`define OFF_MON_RELOAD_LOW 6'h28
`define OFF_MON_RELOAD_HIGH 6'h29
`define OFF_IRQ_ENABLE_ONE 6'h2D
`define OFF_RESERVED_LOW 6'h2E
`define OFF_RESERVED_HIGH 6'h2F
`define RST_DEFINED_MASK 48'h3007FE100FFF
`define WRITABLE_MASK 48'h33FFFFEFFFFF
`define RST_ZERO 8'h00
`define RST_PORT3_DATA 8'hFF
`define RST_SIB_STEP 8'h01
`define RST_BUS_CONTROL_ALT 8'h89
`define VEC_BREAK 16'hFFFE
`define VEC_RESTART 16'hFFFC
`define VEC_NMI 16'hFFFA
`define VEC_LEVEL_TWO 16'hFFF8
`define VEC_LEVEL_ONE 16'hFFF6
`define VEC_TIMER_TWO 16'hFFF4
`define VEC_TIMER_ONE 16'hFFF2
`define VEC_FALL_57 16'hFFF0
`define VEC_RISE_56 16'hFFEE
`define VEC_RISE_55 16'hFFEC
`define VEC_RISE_54 16'hFFEA
`define VEC_SERIAL_BUS 16'hFFE8
`define VEC_UART_RX 16'hFFE6
`define VEC_UART_TX_TIMER_A 16'hFFE4
`define VEC_FALL_53 16'hFFDE
`define VEC_FALL_52 16'hFFDC
`define VEC_RISE_51 16'hFFDA
`define VEC_RISE_50 16'hFFD8
`define VEC_FALL_47 16'hFFD6
`define VEC_FALL_46 16'hFFD4
`define VEC_RISE_45 16'hFFD2
`define VEC_RISE_44 16'hFFD0
`endif

// ===== core/io_page_pkg.sv
// types for the peripheral register page
// source codes are numbered here; the constants header supplies the vector addresses
package io_page_pkg;
   typedef enum logic [4:0] {
      SRC_BREAK = 5'h00,
      SRC_RESTART = 5'h01,
      SRC_NMI = 5'h02,
      SRC_LEVEL_TWO = 5'h03,
      SRC_LEVEL_ONE = 5'h04,
      SRC_TIMER_TWO = 5'h05,
      SRC_TIMER_ONE = 5'h06,
      SRC_FALL_57 = 5'h07,
      SRC_RISE_56 = 5'h08,
      SRC_RISE_55 = 5'h09,
      SRC_RISE_54 = 5'h0A,
      SRC_SERIAL_BUS = 5'h0B,
      SRC_UART_RX = 5'h0C,
      SRC_UART_TX_TIMER_A = 5'h0D,
      SRC_FALL_53 = 5'h0E,
      SRC_FALL_52 = 5'h0F,
      SRC_RISE_51 = 5'h10,
      SRC_RISE_50 = 5'h11,
      SRC_FALL_47 = 5'h12,
      SRC_FALL_46 = 5'h13,
      SRC_RISE_45 = 5'h14,
      SRC_RISE_44 = 5'h15
   } vec_src_t;
endpackage

// ===== core/io_register_map_and_vectors.sv
// peripheral register page (0000-002F) and interrupt vector address lookup
// assumes a single-clock core bus: one read or write strobe per cycle
`timescale 1ns/1ps
`include "io_page_consts.svh"

module io_register_map_and_vectors (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic bus_mode_strap_in,
   input wire logic [15:0] addr_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] wdata_in,
   input wire logic [7:0] sib_step_in,
   input wire logic [15:0] mon_count_in,
   input wire logic [7:0] irq_set_one_in,
   input wire logic [7:0] irq_set_two_in,
   input wire logic vec_req_in,
   input wire logic [4:0] vec_src_in,
   output logic [7:0] rdata_out,
   output logic rdata_valid_out,
   output logic io_sel_out,
   output logic [383:0] bank_out,
   output logic [15:0] vec_addr_out,
   output logic vec_valid_out,
   output logic vec_err_out
);

   logic [7:0] bank_ff [0:`PAGE_BYTES-1];
   logic [7:0] rdata_ff;
   logic rdata_valid_ff;
   logic io_sel_ff;
   logic [15:0] vec_addr_ff;
   logic vec_valid_ff;
   logic vec_err_ff;
   logic strap_meta_ff;
   logic strap_sync_ff;

   // strap is a pin: two flops before the reset image reads it
   always_ff @(posedge clk_in) begin
      strap_meta_ff <= bus_mode_strap_in;
      strap_sync_ff <= strap_meta_ff;
   end

   // decode: the page is the low 48 byte addresses only
   wire io_hit = (addr_in <= `PAGE_TOP);
   wire [5:0] offset = addr_in[5:0];
   wire wr_io = wr_in && io_hit;
   wire rd_io = rd_in && io_hit;
   wire [7:0] bcr_reset_val = strap_sync_ff ? `RST_BUS_CONTROL_ALT : `RST_ZERO;

   genvar gi;
   generate
      for (gi = 0; gi < `PAGE_BYTES; gi = gi + 1) begin : g_byte
         localparam logic [5:0] OFS = 6'(gi);
         localparam bit RST_DEF = 1'((`RST_DEFINED_MASK >> gi) & 48'h1);
         localparam bit WRITABLE = 1'((`WRITABLE_MASK >> gi) & 48'h1);
         logic [7:0] rst_val;
         logic [7:0] hw_set;
         logic [7:0] live_val;
         logic is_live;
         logic wr_hit;
         // reset image: ones for port 3, 01 for step, strap for bus control
         assign rst_val = (OFS == `OFF_PORT3_DATA) ? `RST_PORT3_DATA :
                          (OFS == `OFF_SIB_STEP) ? `RST_SIB_STEP :
                          (OFS == `OFF_BUS_CONTROL) ? bcr_reset_val :
                          `RST_ZERO;
         // hardware event bits; a set in the same cycle as a write wins
         assign hw_set = (OFS == `OFF_IRQ_FLAGS_ONE) ? irq_set_one_in :
                         (OFS == `OFF_IRQ_FLAGS_TWO) ? irq_set_two_in : `RST_ZERO;
         // read-only step and monitor count bytes mirror the owning peripheral every cycle out of reset
         assign is_live = (OFS == `OFF_SIB_STEP) || (OFS == `OFF_MON_COUNT_LOW) ||
                          (OFS == `OFF_MON_COUNT_HIGH);
         assign live_val = (OFS == `OFF_SIB_STEP) ? sib_step_in :
                           (OFS == `OFF_MON_COUNT_LOW) ? mon_count_in[7:0] :
                           mon_count_in[15:8];
         assign wr_hit = wr_io && (offset == OFS) && WRITABLE;
         if (RST_DEF) begin : g_rst
            always_ff @(posedge clk_in) begin
               if (srst_in) begin
                  bank_ff[gi] <= rst_val;
               end else if (is_live) begin
                  bank_ff[gi] <= live_val;
               end else if (wr_hit) begin
                  bank_ff[gi] <= wdata_in | hw_set;
               end else begin
                  bank_ff[gi] <= bank_ff[gi] | hw_set;
               end
            end
         end else begin : g_norst
            // no reset on data bytes: software loads them before use
            always_ff @(posedge clk_in) begin
               if (is_live) begin
                  bank_ff[gi] <= live_val;
               end else if (wr_hit) begin
                  bank_ff[gi] <= wdata_in;
               end
            end
         end
         assign bank_out[gi*8 +: 8] = bank_ff[gi];
      end
   endgenerate

   // named views of the page, one per register
   wire [7:0] port0_data = bank_ff[`OFF_PORT0_DATA];
   wire [7:0] port1_data = bank_ff[`OFF_PORT1_DATA];
   wire [7:0] port2_data = bank_ff[`OFF_PORT2_DATA];
   wire [7:0] port3_data = bank_ff[`OFF_PORT3_DATA];
   wire [7:0] port0_direction = bank_ff[`OFF_PORT0_DIR];
   wire [7:0] port1_direction = bank_ff[`OFF_PORT1_DIR];
   wire [7:0] port2_direction = bank_ff[`OFF_PORT2_DIR];
   wire [7:0] port3_chip_select = bank_ff[`OFF_PORT3_CS];
   wire [7:0] irq_flags_two = bank_ff[`OFF_IRQ_FLAGS_TWO];
   wire [7:0] irq_enable_two = bank_ff[`OFF_IRQ_ENABLE_TWO];
   wire [7:0] timer_control_one = bank_ff[`OFF_TIMER_CTRL_ONE];
   wire [7:0] timer_control_two = bank_ff[`OFF_TIMER_CTRL_TWO];
   wire [7:0] timer1_reload_low = bank_ff[`OFF_TIMER1_RELOAD_LOW];
   wire [7:0] timer1_reload_high = bank_ff[`OFF_TIMER1_RELOAD_HIGH];
   wire [7:0] timer2_reload_low = bank_ff[`OFF_TIMER2_RELOAD_LOW];
   wire [7:0] timer2_reload_high = bank_ff[`OFF_TIMER2_RELOAD_HIGH];
   wire [7:0] timer1_count_low = bank_ff[`OFF_TIMER1_COUNT_LOW];
   wire [7:0] timer1_count_high = bank_ff[`OFF_TIMER1_COUNT_HIGH];
   wire [7:0] timer2_count_low = bank_ff[`OFF_TIMER2_COUNT_LOW];
   wire [7:0] timer2_count_high = bank_ff[`OFF_TIMER2_COUNT_HIGH];
   wire [7:0] sib_sequence_step = bank_ff[`OFF_SIB_STEP];
   wire [7:0] sib_shift_byte0 = bank_ff[`OFF_SIB_SHIFT0];
   wire [7:0] sib_shift_byte1 = bank_ff[`OFF_SIB_SHIFT1];
   wire [7:0] sib_shift_byte2 = bank_ff[`OFF_SIB_SHIFT2];
   wire [7:0] sib_shift_byte3 = bank_ff[`OFF_SIB_SHIFT3];
   wire [7:0] sib_control_status = bank_ff[`OFF_SIB_CTRL];
   wire [7:0] sib_node_address = bank_ff[`OFF_SIB_NODE];
   wire [7:0] bus_control = bank_ff[`OFF_BUS_CONTROL];
   wire [7:0] port4_data = bank_ff[`OFF_PORT4_DATA];
   wire [7:0] port5_data = bank_ff[`OFF_PORT5_DATA];
   wire [7:0] port4_direction = bank_ff[`OFF_PORT4_DIR];
   wire [7:0] port5_direction = bank_ff[`OFF_PORT5_DIR];
   wire [7:0] port6_data = bank_ff[`OFF_PORT6_DATA];
   wire [7:0] port6_direction = bank_ff[`OFF_PORT6_DIR];
   wire [7:0] uart_control_status = bank_ff[`OFF_UART_CTRL];
   wire [7:0] uart_data = bank_ff[`OFF_UART_DATA];
   wire [7:0] timer_a_reload_low = bank_ff[`OFF_TIMER_A_RELOAD_LOW];
   wire [7:0] timer_a_reload_high = bank_ff[`OFF_TIMER_A_RELOAD_HIGH];
   wire [7:0] timer_a_count_low = bank_ff[`OFF_TIMER_A_COUNT_LOW];
   wire [7:0] timer_a_count_high = bank_ff[`OFF_TIMER_A_COUNT_HIGH];
   wire [7:0] monitor_timer_reload_low = bank_ff[`OFF_MON_RELOAD_LOW];
   wire [7:0] monitor_timer_reload_high = bank_ff[`OFF_MON_RELOAD_HIGH];
   wire [7:0] monitor_timer_count_low = bank_ff[`OFF_MON_COUNT_LOW];
   wire [7:0] monitor_timer_count_high = bank_ff[`OFF_MON_COUNT_HIGH];
   wire [7:0] irq_flags_one = bank_ff[`OFF_IRQ_FLAGS_ONE];
   wire [7:0] irq_enable_one = bank_ff[`OFF_IRQ_ENABLE_ONE];

   // read select; offsets 30-3F never reach here but keep the index in range
   logic [7:0] nxt_rdata;
   always_comb begin
      nxt_rdata = `RST_ZERO;
      unique case (offset)
         `OFF_PORT0_DATA: nxt_rdata = port0_data;
         `OFF_PORT1_DATA: nxt_rdata = port1_data;
         `OFF_PORT2_DATA: nxt_rdata = port2_data;
         `OFF_PORT3_DATA: nxt_rdata = port3_data;
         `OFF_PORT0_DIR: nxt_rdata = port0_direction;
         `OFF_PORT1_DIR: nxt_rdata = port1_direction;
         `OFF_PORT2_DIR: nxt_rdata = port2_direction;
         `OFF_PORT3_CS: nxt_rdata = port3_chip_select;
         `OFF_IRQ_FLAGS_TWO: nxt_rdata = irq_flags_two;
         `OFF_IRQ_ENABLE_TWO: nxt_rdata = irq_enable_two;
         `OFF_TIMER_CTRL_ONE: nxt_rdata = timer_control_one;
         `OFF_TIMER_CTRL_TWO: nxt_rdata = timer_control_two;
         `OFF_TIMER1_RELOAD_LOW: nxt_rdata = timer1_reload_low;
         `OFF_TIMER1_RELOAD_HIGH: nxt_rdata = timer1_reload_high;
         `OFF_TIMER2_RELOAD_LOW: nxt_rdata = timer2_reload_low;
         `OFF_TIMER2_RELOAD_HIGH: nxt_rdata = timer2_reload_high;
         `OFF_TIMER1_COUNT_LOW: nxt_rdata = timer1_count_low;
         `OFF_TIMER1_COUNT_HIGH: nxt_rdata = timer1_count_high;
         `OFF_TIMER2_COUNT_LOW: nxt_rdata = timer2_count_low;
         `OFF_TIMER2_COUNT_HIGH: nxt_rdata = timer2_count_high;
         `OFF_SIB_STEP: nxt_rdata = sib_sequence_step;
         `OFF_SIB_SHIFT0: nxt_rdata = sib_shift_byte0;
         `OFF_SIB_SHIFT1: nxt_rdata = sib_shift_byte1;
         `OFF_SIB_SHIFT2: nxt_rdata = sib_shift_byte2;
         `OFF_SIB_SHIFT3: nxt_rdata = sib_shift_byte3;
         `OFF_SIB_CTRL: nxt_rdata = sib_control_status;
         `OFF_SIB_NODE: nxt_rdata = sib_node_address;
         `OFF_BUS_CONTROL: nxt_rdata = bus_control;
         `OFF_PORT4_DATA: nxt_rdata = port4_data;
         `OFF_PORT5_DATA: nxt_rdata = port5_data;
         `OFF_PORT4_DIR: nxt_rdata = port4_direction;
         `OFF_PORT5_DIR: nxt_rdata = port5_direction;
         `OFF_PORT6_DATA: nxt_rdata = port6_data;
         `OFF_PORT6_DIR: nxt_rdata = port6_direction;
         `OFF_UART_CTRL: nxt_rdata = uart_control_status;
         `OFF_UART_DATA: nxt_rdata = uart_data;
         `OFF_TIMER_A_RELOAD_LOW: nxt_rdata = timer_a_reload_low;
         `OFF_TIMER_A_RELOAD_HIGH: nxt_rdata = timer_a_reload_high;
         `OFF_TIMER_A_COUNT_LOW: nxt_rdata = timer_a_count_low;
         `OFF_TIMER_A_COUNT_HIGH: nxt_rdata = timer_a_count_high;
         `OFF_MON_RELOAD_LOW: nxt_rdata = monitor_timer_reload_low;
         `OFF_MON_RELOAD_HIGH: nxt_rdata = monitor_timer_reload_high;
         `OFF_MON_COUNT_LOW: nxt_rdata = monitor_timer_count_low;
         `OFF_MON_COUNT_HIGH: nxt_rdata = monitor_timer_count_high;
         `OFF_IRQ_FLAGS_ONE: nxt_rdata = irq_flags_one;
         `OFF_IRQ_ENABLE_ONE: nxt_rdata = irq_enable_one;
         // reserved bytes never load, so a fixed value keeps reads stable
         `OFF_RESERVED_LOW, `OFF_RESERVED_HIGH: nxt_rdata = `RST_ZERO;
         default: nxt_rdata = `RST_ZERO;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rdata_ff <= `RST_ZERO;
         rdata_valid_ff <= 1'b0;
         io_sel_ff <= 1'b0;
      end else begin
         rdata_valid_ff <= rd_io;
         io_sel_ff <= (rd_in || wr_in) && io_hit;
         if (rd_io) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // vector lookup; address given is the low byte, high byte sits at +1
   logic [15:0] nxt_vec;
   wire hit_break = (vec_src_in == io_page_pkg::SRC_BREAK);
   wire hit_restart = (vec_src_in == io_page_pkg::SRC_RESTART);
   wire hit_nmi = (vec_src_in == io_page_pkg::SRC_NMI);
   wire hit_level_two = (vec_src_in == io_page_pkg::SRC_LEVEL_TWO);
   wire hit_level_one = (vec_src_in == io_page_pkg::SRC_LEVEL_ONE);
   wire hit_timer_two = (vec_src_in == io_page_pkg::SRC_TIMER_TWO);
   wire hit_timer_one = (vec_src_in == io_page_pkg::SRC_TIMER_ONE);
   wire hit_fall_57 = (vec_src_in == io_page_pkg::SRC_FALL_57);
   wire hit_rise_56 = (vec_src_in == io_page_pkg::SRC_RISE_56);
   wire hit_rise_55 = (vec_src_in == io_page_pkg::SRC_RISE_55);
   wire hit_rise_54 = (vec_src_in == io_page_pkg::SRC_RISE_54);
   wire hit_serial_bus = (vec_src_in == io_page_pkg::SRC_SERIAL_BUS);
   wire hit_uart_rx = (vec_src_in == io_page_pkg::SRC_UART_RX);
   wire hit_uart_tx_timer_a = (vec_src_in == io_page_pkg::SRC_UART_TX_TIMER_A);
   wire hit_fall_53 = (vec_src_in == io_page_pkg::SRC_FALL_53);
   wire hit_fall_52 = (vec_src_in == io_page_pkg::SRC_FALL_52);
   wire hit_rise_51 = (vec_src_in == io_page_pkg::SRC_RISE_51);
   wire hit_rise_50 = (vec_src_in == io_page_pkg::SRC_RISE_50);
   wire hit_fall_47 = (vec_src_in == io_page_pkg::SRC_FALL_47);
   wire hit_fall_46 = (vec_src_in == io_page_pkg::SRC_FALL_46);
   wire hit_rise_45 = (vec_src_in == io_page_pkg::SRC_RISE_45);
   wire hit_rise_44 = (vec_src_in == io_page_pkg::SRC_RISE_44);
   // a code outside the table raises the error pulse instead of valid
   wire vec_known = hit_break |
                    hit_restart |
                    hit_nmi |
                    hit_level_two |
                    hit_level_one |
                    hit_timer_two |
                    hit_timer_one |
                    hit_fall_57 |
                    hit_rise_56 |
                    hit_rise_55 |
                    hit_rise_54 |
                    hit_serial_bus |
                    hit_uart_rx |
                    hit_uart_tx_timer_a |
                    hit_fall_53 |
                    hit_fall_52 |
                    hit_rise_51 |
                    hit_rise_50 |
                    hit_fall_47 |
                    hit_fall_46 |
                    hit_rise_45 |
                    hit_rise_44;
   always_comb begin
      nxt_vec = `VEC_RESTART;
      unique case (vec_src_in)
         io_page_pkg::SRC_BREAK: nxt_vec = `VEC_BREAK;
         io_page_pkg::SRC_RESTART: nxt_vec = `VEC_RESTART;
         io_page_pkg::SRC_NMI: nxt_vec = `VEC_NMI;
         io_page_pkg::SRC_LEVEL_TWO: nxt_vec = `VEC_LEVEL_TWO;
         io_page_pkg::SRC_LEVEL_ONE: nxt_vec = `VEC_LEVEL_ONE;
         io_page_pkg::SRC_TIMER_TWO: nxt_vec = `VEC_TIMER_TWO;
         io_page_pkg::SRC_TIMER_ONE: nxt_vec = `VEC_TIMER_ONE;
         io_page_pkg::SRC_FALL_57: nxt_vec = `VEC_FALL_57;
         io_page_pkg::SRC_RISE_56: nxt_vec = `VEC_RISE_56;
         io_page_pkg::SRC_RISE_55: nxt_vec = `VEC_RISE_55;
         io_page_pkg::SRC_RISE_54: nxt_vec = `VEC_RISE_54;
         io_page_pkg::SRC_SERIAL_BUS: nxt_vec = `VEC_SERIAL_BUS;
         io_page_pkg::SRC_UART_RX: nxt_vec = `VEC_UART_RX;
         // shared pair: the handler must poll both sources
         io_page_pkg::SRC_UART_TX_TIMER_A: nxt_vec = `VEC_UART_TX_TIMER_A;
         io_page_pkg::SRC_FALL_53: nxt_vec = `VEC_FALL_53;
         io_page_pkg::SRC_FALL_52: nxt_vec = `VEC_FALL_52;
         io_page_pkg::SRC_RISE_51: nxt_vec = `VEC_RISE_51;
         io_page_pkg::SRC_RISE_50: nxt_vec = `VEC_RISE_50;
         io_page_pkg::SRC_FALL_47: nxt_vec = `VEC_FALL_47;
         io_page_pkg::SRC_FALL_46: nxt_vec = `VEC_FALL_46;
         io_page_pkg::SRC_RISE_45: nxt_vec = `VEC_RISE_45;
         io_page_pkg::SRC_RISE_44: nxt_vec = `VEC_RISE_44;
         // unknown codes fall back to restart rather than a random fetch
         default: nxt_vec = `VEC_RESTART;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         vec_addr_ff <= `VEC_RESTART;
         vec_valid_ff <= 1'b0;
         vec_err_ff <= 1'b0;
      end else begin
         vec_valid_ff <= vec_req_in && vec_known;
         vec_err_ff <= vec_req_in && !vec_known;
         if (vec_req_in) begin
            vec_addr_ff <= nxt_vec;
         end
      end
   end

   assign rdata_out = rdata_ff;
   assign rdata_valid_out = rdata_valid_ff;
   assign io_sel_out = io_sel_ff;
   assign vec_addr_out = vec_addr_ff;
   assign vec_valid_out = vec_valid_ff;
   assign vec_err_out = vec_err_ff;

endmodule

// ===== verification/periph_stub.sv
// monitor timer and step source beyond the page
// assumes tb pulses tick_in between reads
`timescale 1ns/1ps
module periph_stub (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic tick_in,
   output logic [15:0] count_out,
   output logic [7:0] step_out
);
   // step held at its idle value; no traffic modelled
   assign step_out = 8'h01;
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         count_out <= 16'hA55A;
      end else if (tick_in) begin
         count_out <= count_out - 16'h0001;
      end
   end
endmodule

// ===== verification/io_page_monitor.sv
// checker for page latencies, read-only bytes, resets, break vector
// assumes bind to the page top, ports named
`timescale 1ns/1ps
module io_page_monitor (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic bus_mode_strap_in,
   input wire logic [15:0] addr_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] sib_step_in,
   input wire logic [15:0] mon_count_in,
   input wire logic vec_req_in,
   input wire logic [4:0] vec_src_in,
   input wire logic rdata_valid_out,
   input wire logic io_sel_out,
   input wire logic [383:0] bank_out,
   input wire logic [15:0] vec_addr_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);
   sequence s_in_rd;
      rd_in && addr_in <= 16'h002F;
   endsequence
   sequence s_ans;
      rdata_valid_out && io_sel_out;
   endsequence
   property p_rd_lat;
      s_in_rd |=> s_ans;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_out_page;
      (rd_in || wr_in) && addr_in > 16'h002F |=> !io_sel_out && !rdata_valid_out;
   endproperty
   a_out_page: assert property (p_out_page) else $error("outside page answered");
   property p_mon_ro;
      wr_in && addr_in == 16'h002A |=> bank_out[343:336] == $past(mon_count_in[7:0]);
   endproperty
   a_mon_ro: assert property (p_mon_ro) else $error("counter byte written");
   property p_step_ro;
      wr_in && addr_in == 16'h0014 |=> bank_out[167:160] == $past(sib_step_in);
   endproperty
   a_step_ro: assert property (p_step_ro) else $error("step byte written");
   property p_port3;
      $fell(srst_in) |-> bank_out[31:24] == 8'hFF;
   endproperty
   a_port3: assert property (p_port3) else $error("port3 reset wrong");
   property p_irq;
      $fell(srst_in) |-> {bank_out[367:352], bank_out[79:64]} == 32'h00000000;
   endproperty
   a_irq: assert property (p_irq) else $error("irq reset wrong");
   property p_bus;
      $fell(srst_in) |-> bank_out[223:216] == ($past(bus_mode_strap_in) ? 8'h89 : 8'h00);
   endproperty
   a_bus: assert property (p_bus) else $error("bus control reset wrong");
   property p_brk;
      vec_req_in && vec_src_in == 5'h00 |=> vec_addr_out == 16'hFFFE;
   endproperty
   a_brk: assert property (p_brk) else $error("break vector wrong");
endmodule

// ===== verification/tb.sv
// bench for the page registers and vector lookup
// assumes page, checker and stub compiled first
`timescale 1ns/1ps
module tb;
   logic clk_in, srst_in, strap, wr, rd, vreq, tick, rv, sel, vv, ve;
   logic [15:0] addr, mc, va;
   logic [7:0] wd, st, s1, s2, rdata;
   logic [4:0] src;
   logic [383:0] bank;
   int fail_count, checked, cycles;
   io_register_map_and_vectors dut (.clk_in(clk_in), .srst_in(srst_in),
      .bus_mode_strap_in(strap), .addr_in(addr), .wr_in(wr), .rd_in(rd), .wdata_in(wd),
      .sib_step_in(st), .mon_count_in(mc), .irq_set_one_in(s1), .irq_set_two_in(s2),
      .vec_req_in(vreq), .vec_src_in(src), .rdata_out(rdata), .rdata_valid_out(rv),
      .io_sel_out(sel), .bank_out(bank), .vec_addr_out(va), .vec_valid_out(vv),
      .vec_err_out(ve));
   periph_stub stub (.clk_in(clk_in), .srst_in(srst_in), .tick_in(tick), .count_out(mc),
      .step_out(st));
   initial begin
      clk_in = 0;
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic step_in(input logic [7:0] a, input logic [7:0] b, input logic t);
      @(posedge clk_in) #1;
      s1 = a;
      s2 = b;
      tick = t;
   endtask
   task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_in) #1;
      addr = a;
      wd = d;
      wr = 1;
      @(posedge clk_in) #1;
      wr = 0;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_in) #1;
      addr = a;
      rd = 1;
      @(posedge clk_in) #1;
      rd = 0;
      check("valid", {15'h0000, rv & sel}, {15'h0000, a <= 16'h002F});
      if (a <= 16'h002F)
         check("rdata", {8'h00, rdata}, {8'h00, e});
   endtask
   task automatic vec_chk(input int i, input logic [15:0] e, input logic ok);
      @(posedge clk_in) #1;
      src = 5'(i);
      vreq = 1;
      @(posedge clk_in) #1;
      vreq = 0;
      check("vector", va, e);
      check("vec_flags", {14'h0000, vv, ve}, ok ? 16'h0002 : 16'h0001);
   endtask
   task automatic do_reset(input logic s);
      strap = s;
      srst_in = 1;
      repeat (16) @(posedge clk_in);
      #1 srst_in = 0;
      // bytes 0C-13, 15-18, 23-2B, 2E-2F have no reset value
      for (int i = 0; i < 46; i++)
         if (i < 12 || i == 20 || (i > 24 && i < 35) || i > 43)
            rd_chk(16'(i), i == 3 ? 8'hFF : i == 20 ? 8'h01 : i == 27 && s ? 8'h89 : 8'h00);
   endtask
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         summarize;
      end
   end
   initial begin
      {srst_in, strap, wr, rd, vreq, tick} = 6'h20;
      {addr, wd, s1, s2, src} = 45'h0;
      do_reset(1'b0);
      bus_wr(16'h0009, 8'h5A);
      rd_chk(16'h0009, 8'h5A);
      bus_wr(16'h002A, 8'h00);
      bus_wr(16'h002B, 8'h00);
      bus_wr(16'h0014, 8'hEE);
      bus_wr(16'h002E, 8'h77);
      step_in(8'h3C, 8'h81, 1'b1);
      step_in(8'h00, 8'h00, 1'b0);
      rd_chk(16'h002A, 8'h59);
      rd_chk(16'h002B, 8'hA5);
      rd_chk(16'h0014, 8'h01);
      rd_chk(16'h002E, 8'h00);
      rd_chk(16'h002C, 8'h3C);
      bus_wr(16'h0008, 8'h00);
      rd_chk(16'h0008, 8'h00);
      bus_wr(16'h0030, 8'h33);
      rd_chk(16'h0030, 8'h00);
      // codes 0E-15 follow the two unused pairs
      for (int i = 0; i < 22; i++)
         vec_chk(i, i < 14 ? 16'hFFFE - 16'(2 * i) : 16'hFFDE - 16'(2 * i - 28), 1'b1);
      vec_chk(22, 16'hFFFC, 1'b0);
      do_reset(1'b1);
      summarize;
   end
endmodule
bind io_register_map_and_vectors io_page_monitor mon (.clk_in(clk_in), .srst_in(srst_in),
   .bus_mode_strap_in(bus_mode_strap_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
   .sib_step_in(sib_step_in), .mon_count_in(mon_count_in), .vec_req_in(vec_req_in),
   .vec_src_in(vec_src_in), .rdata_valid_out(rdata_valid_out), .io_sel_out(io_sel_out),
   .bank_out(bank_out), .vec_addr_out(vec_addr_out));
